// File: rtl/fifo_flags_consts.svh
// Constants for the dual-port FIFO with flags, mailboxes and parity.
`ifndef FIFO_FLAGS_CONSTS_SVH
`define FIFO_FLAGS_CONSTS_SVH
`define FIFO_DEPTH        64
`define FIFO_WIDTH        36
`define BYTE_BITS         9
`define PTR_BITS          7
`define OFFSET_BITS       5
`define OFFSET_SEL_HH     5'h10
`define OFFSET_SEL_HL     5'h0C
`define OFFSET_SEL_LH     5'h08
`define OFFSET_SEL_LL     5'h04
`define OFFSET_RESET      5'h04
`define FLAG_SKEW_NS      8
`define CLK_PERIOD_NS     8
`define FLAG_SKEW_CYCLES  ((`FLAG_SKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: rtl/fifo_flags_mailbox.sv
// Dual-port FIFO with synchronized flags, mailbox registers and parity.
// What this block does
// - Empty flag low means empty; FIFO reads are then ignored.
// - Read pointer advances once per word loaded into the output register.
// - A new word needs three read-clock cycles; empty stays low two.
// - Empty flag rises on second read-clock edge after the write.
// - A write too close to a read-clock edge defers synchronization one cycle.
// - Full flag low means no free location; writes are ignored.
// - Write pointer advances once per accepted FIFO write.
// - Freed location writable after three write-clock cycles; full rises second edge.
// - A read too close to a write-clock edge defers synchronization one cycle.
// - Almost-empty low at X or fewer words, high at X+1 or more.
// - Almost-empty rises on second qualifying read-clock edge after the write.
// - Almost-full low at 64-X or more words, high at 64-(X+1) or fewer.
// - Almost-full rises on second qualifying write-clock edge after the read.
// - Mail writes store 36 port bits into the opposite mail register.
// - A mail write drives its flag low; further writes ignored while low.
// - Port B shows FIFO or mail-to-B by select; port A shows mail-to-A.
// - A mail read on the far port sets that mail flag high.
// - Reading a mail register leaves its contents unchanged.
// - Each port checks four 9-bit bytes; error output low on mismatch.
// - During a mail read with parity generation the error output is held high.
// - Writes store all bits; reads may substitute generated byte parity.
// - FIFO parity is generated before the output register is loaded.
// - Reset release loads offset X as 16, 12, 8 or 4 from selects.
// - FIFO write needs select low, write, enable, no mail, not full.
// - FIFO read needs select low, read, enable, no mail, not empty.
// - Reset clears pointers, flags low, almost-full high, mail and parity-error flags high.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flags_consts.svh"
module fifo_flags_mailbox
  import fifo_flags_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int WIDTH = `FIFO_WIDTH
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Port clocks, sampled as ordinary inputs.
  input  wire logic             write_port_clock,
  input  wire logic             read_port_clock,
  // Port A controls.
  input  wire logic             port_a_select_n,
  input  wire logic             port_a_dir,
  input  wire logic             port_a_en,
  input  wire logic             port_a_mail_sel,
  input  wire logic             port_a_parity_gen_en,
  // Port B controls.
  input  wire logic             port_b_select_n,
  input  wire logic             port_b_dir,
  input  wire logic             port_b_en,
  input  wire logic             port_b_mail_sel,
  input  wire logic             port_b_parity_gen_en,
  // Configuration.
  input  wire logic             parity_odd_sel,
  input  wire logic             offset_sel0,
  input  wire logic             offset_sel1,
  // Port A data pins.
  input  wire logic [WIDTH-1:0] a_data_in,
  output logic      [WIDTH-1:0] a_data_out,
  output logic                  a_data_oe,
  // Port B data pins.
  input  wire logic [WIDTH-1:0] b_data_in,
  output logic      [WIDTH-1:0] b_data_out,
  output logic                  b_data_oe,
  // Flags.
  output logic                  fifo_not_empty_n,
  output logic                  almost_empty_n,
  output logic                  fifo_not_full_n,
  output logic                  almost_full_n,
  output logic                  mail_to_b_flag_n,
  output logic                  mail_to_a_flag_n,
  output logic                  port_a_parity_err_n,
  output logic                  port_b_parity_err_n
);
  localparam int PW = `PTR_BITS;
  localparam int NB = WIDTH / `BYTE_BITS;

  initial begin
    if (DEPTH != (1 << (PW - 1))) $error("fifo_flags_mailbox: DEPTH must match PTR_BITS.");
    if (WIDTH % `BYTE_BITS != 0) $error("fifo_flags_mailbox: WIDTH must be whole bytes.");
  end

  // Generated parity bit for the low eight bits of one byte.
  function automatic logic gen_bit(input logic [7:0] low8, input logic odd);
    gen_bit = odd ? ~(^low8) : (^low8);
  endfunction

  // Replaces the top bit of every byte with generated parity.
  function automatic logic [WIDTH-1:0] with_parity(input logic [WIDTH-1:0] w,
                                                  input logic odd);
    logic [WIDTH-1:0] r;
    r = w;
    for (int i = 0; i < NB; i++) begin
      r[i*9+8] = gen_bit(w[i*9 +: 8], odd);
    end
    with_parity = r;
  endfunction

  // True when any byte has a parity count over all nine bits not matching the sense.
  function automatic logic parity_bad(input logic [WIDTH-1:0] w, input logic odd);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < NB; i++) begin
      bad = bad | (odd ? (^(~w[i*9 +: 9])) : ~(^(~w[i*9 +: 9])));
    end
    parity_bad = bad;
  endfunction

  // Decodes the control pins of one port for an edge of its clock.
  function automatic port_op_type decode(input port_ctrl_type c);
    port_op_type o;
    o.fifo_wr = ~c.select_n & c.dir & c.en & ~c.mail_sel;
    o.mail_wr = ~c.select_n & c.dir & c.en & c.mail_sel;
    o.fifo_rd = ~c.select_n & ~c.dir & c.en & ~c.mail_sel;
    o.mail_rd = ~c.select_n & ~c.dir & c.en & c.mail_sel;
    decode = o;
  endfunction

  port_ctrl_type           ctrl_a, ctrl_b;
  port_op_type             op_a, op_b;
  logic                    wclk_d_r, rclk_d_r;
  logic                    a_edge, b_edge;
  logic                    wr_acc, rd_acc;
  logic                    buf_in_ready, buf_out_valid;
  logic [WIDTH-1:0]        buf_out_data;
  logic [WIDTH-1:0]        mem [DEPTH];
  logic [PW-2:0]           mem_wptr_r, mem_wptr_nxt;
  logic [PW-1:0]           wptr_r, wptr_nxt;
  logic [PW-1:0]           rptr_r, rptr_nxt;
  logic [PW-1:0]           rsync_r, rsync_nxt;
  logic [PW-1:0]           wsync_r, wsync_nxt;
  logic                    rsync_vld_r, rsync_vld_nxt;
  logic                    full_n_r, full_n_nxt;
  logic                    afull_n_r, afull_n_nxt;
  logic                    empty_n_r, empty_n_nxt;
  logic                    aempty_n_r, aempty_n_nxt;
  logic [PW-1:0]           wfill, rfill;
  logic [`OFFSET_BITS-1:0] x_r, x_nxt;
  logic                    x_loaded_r;
  logic [WIDTH-1:0]        out_reg_r, out_reg_nxt;
  logic [WIDTH-1:0]        mail_b_r, mail_b_nxt;
  logic [WIDTH-1:0]        mail_a_r, mail_a_nxt;
  logic                    mflag_b_r, mflag_b_nxt;
  logic                    mflag_a_r, mflag_a_nxt;
  logic [WIDTH-1:0]        a_out_nxt, b_out_nxt;
  logic                    pea_nxt, peb_nxt;
  logic                    a_gen_rd, b_gen_rd;

  // Port control decode; port clock edges become one-cycle enables.
  always_comb begin
    ctrl_a = '{port_a_select_n, port_a_dir, port_a_en, port_a_mail_sel,
               port_a_parity_gen_en};
    ctrl_b = '{port_b_select_n, port_b_dir, port_b_en, port_b_mail_sel,
               port_b_parity_gen_en};
    op_a   = decode(ctrl_a);
    op_b   = decode(ctrl_b);
    a_edge = write_port_clock & ~wclk_d_r;
    b_edge = read_port_clock & ~rclk_d_r;
    wr_acc = a_edge & op_a.fifo_wr & full_n_r & buf_in_ready;
    rd_acc = b_edge & op_b.fifo_rd & empty_n_r;
  end

  // Accepted words wait here until they are copied into the array.
  two_entry_buffer #(.WIDTH(WIDTH)) wr_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (wr_acc),
    .in_ready  (buf_in_ready),
    .in_data   (a_data_in),
    .out_valid (buf_out_valid),
    .out_ready (mem_wptr_r != rptr_r[PW-2:0] || wptr_r == rptr_r || buf_out_valid),
    .out_data  (buf_out_data)
  );

  // Write side: pointer, read-pointer synchronizer and write-clock flags.
  always_comb begin
    wptr_nxt      = wptr_r + {{(PW-1){1'b0}}, wr_acc};
    mem_wptr_nxt  = mem_wptr_r + {{(PW-2){1'b0}}, buf_out_valid};
    rsync_nxt     = rsync_r;
    rsync_vld_nxt = rsync_vld_r;
    full_n_nxt    = full_n_r;
    afull_n_nxt   = afull_n_r;
    wfill         = wptr_nxt - rsync_r;
    if (a_edge) begin
      // a read in this same cycle is seen one edge later
      rsync_nxt     = rptr_r;
      rsync_vld_nxt = 1'b1;
      // second stage of the full flag
      full_n_nxt    = rsync_vld_r & (wfill != PW'(DEPTH));
      afull_n_nxt   = (wfill <= PW'(DEPTH) - PW'(x_r) - PW'(1));
    end
  end

  // Read side: pointer, output register and read-clock flags.
  always_comb begin
    rptr_nxt     = rptr_r + {{(PW-1){1'b0}}, rd_acc};
    out_reg_nxt  = out_reg_r;
    wsync_nxt    = wsync_r;
    empty_n_nxt  = empty_n_r;
    aempty_n_nxt = aempty_n_r;
    rfill        = wsync_r - rptr_nxt;
    if (rd_acc) begin
      // parity made between array and output register
      out_reg_nxt = port_b_parity_gen_en ? with_parity(mem[rptr_r[PW-2:0]], parity_odd_sel)
                                         : mem[rptr_r[PW-2:0]];
    end
    if (b_edge) begin
      // a write in this same cycle is seen one edge later
      wsync_nxt    = wptr_r;
      // second stage of the empty flag
      empty_n_nxt  = (wsync_r != rptr_nxt);
      aempty_n_nxt = (rfill > PW'(x_r));
    end
  end

  // Mailboxes, offset capture and registered pin outputs.
  always_comb begin
    mail_b_nxt  = mail_b_r;
    mail_a_nxt  = mail_a_r;
    mflag_b_nxt = mflag_b_r;
    mflag_a_nxt = mflag_a_r;
    // a far-side mail read sets the flag
    if (b_edge & op_b.mail_rd) mflag_b_nxt = 1'b1;
    if (a_edge & op_a.mail_rd) mflag_a_nxt = 1'b1;
    // store only while the flag is high
    if (a_edge & op_a.mail_wr & mflag_b_r) begin
      mail_b_nxt  = a_data_in;
      mflag_b_nxt = 1'b0;
    end
    if (b_edge & op_b.mail_wr & mflag_a_r) begin
      mail_a_nxt  = b_data_in;
      mflag_a_nxt = 1'b0;
    end
    // offset preset taken at the first edge after reset release
    case ({offset_sel1, offset_sel0})
      2'h3:    x_nxt = `OFFSET_SEL_HH;
      2'h2:    x_nxt = `OFFSET_SEL_HL;
      2'h1:    x_nxt = `OFFSET_SEL_LH;
      default: x_nxt = `OFFSET_SEL_LL;
    endcase
    if (x_loaded_r) x_nxt = x_r;
    // output selection with optional parity substitution
    a_out_nxt = port_a_parity_gen_en ? with_parity(mail_a_r, parity_odd_sel) : mail_a_r;
    if (port_b_mail_sel) begin
      b_out_nxt = port_b_parity_gen_en ? with_parity(mail_b_r, parity_odd_sel) : mail_b_r;
    end else begin
      b_out_nxt = out_reg_r;
    end
    a_gen_rd = op_a.mail_rd & port_a_parity_gen_en;
    b_gen_rd = op_b.mail_rd & port_b_parity_gen_en;
    // checking, held high while the trees generate
    pea_nxt = a_gen_rd | ~parity_bad(a_data_in, parity_odd_sel);
    peb_nxt = b_gen_rd | ~parity_bad(b_data_in, parity_odd_sel);
  end

  // Array write from the buffer head.
  always_ff @(posedge sys_clk) begin
    if (buf_out_valid) mem[mem_wptr_r] <= buf_out_data;
  end

  // State registers for all groups.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wclk_d_r            <= 1'b1; // Held high so a high pin gives no false edge.
      rclk_d_r            <= 1'b1;
      wptr_r              <= '0;
      rptr_r              <= '0;
      mem_wptr_r          <= '0;
      rsync_r             <= '0;
      wsync_r             <= '0;
      rsync_vld_r         <= 1'b0;
      full_n_r            <= 1'b0;
      afull_n_r           <= 1'b1;
      empty_n_r           <= 1'b0;
      aempty_n_r          <= 1'b0;
      out_reg_r           <= '0;
      mail_b_r            <= '0;
      mail_a_r            <= '0;
      mflag_b_r           <= 1'b1;
      mflag_a_r           <= 1'b1;
      x_r                 <= `OFFSET_RESET;
      x_loaded_r          <= 1'b0;
      a_data_out          <= '0;
      b_data_out          <= '0;
      port_a_parity_err_n <= 1'b1;
      port_b_parity_err_n <= 1'b1;
    end else begin
      wclk_d_r            <= write_port_clock;
      rclk_d_r            <= read_port_clock;
      wptr_r              <= wptr_nxt;
      rptr_r              <= rptr_nxt;
      mem_wptr_r          <= mem_wptr_nxt;
      rsync_r             <= rsync_nxt;
      wsync_r             <= wsync_nxt;
      rsync_vld_r         <= rsync_vld_nxt;
      full_n_r            <= full_n_nxt;
      afull_n_r           <= afull_n_nxt;
      empty_n_r           <= empty_n_nxt;
      aempty_n_r          <= aempty_n_nxt;
      out_reg_r           <= out_reg_nxt;
      mail_b_r            <= mail_b_nxt;
      mail_a_r            <= mail_a_nxt;
      mflag_b_r           <= mflag_b_nxt;
      mflag_a_r           <= mflag_a_nxt;
      x_r                 <= x_nxt;
      x_loaded_r          <= 1'b1;
      a_data_out          <= a_out_nxt;
      b_data_out          <= b_out_nxt;
      port_a_parity_err_n <= pea_nxt;
      port_b_parity_err_n <= peb_nxt;
    end
  end

  // Pin drive and flag outputs.
  assign a_data_oe        = ~port_a_select_n & ~port_a_dir;
  assign b_data_oe        = ~port_b_select_n & ~port_b_dir;
  assign fifo_not_empty_n = empty_n_r;
  assign almost_empty_n   = aempty_n_r;
  assign fifo_not_full_n  = full_n_r;
  assign almost_full_n    = afull_n_r;
  assign mail_to_b_flag_n = mflag_b_r;
  assign mail_to_a_flag_n = mflag_a_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Checks on pointer, flag and mailbox behaviour.
  no_write_full_a: assert property (a_edge && !full_n_r |=> wptr_r == $past(wptr_r))
    else $error("Write pointer moved while full.");
  no_read_empty_a: assert property (b_edge && !empty_n_r |=> rptr_r == $past(rptr_r))
    else $error("Read pointer moved while empty.");
  rptr_step_a: assert property (rd_acc |=> rptr_r == $past(rptr_r) + 7'h01)
    else $error("Read pointer did not step by one.");
  wptr_step_a: assert property (wr_acc |=> wptr_r == $past(wptr_r) + 7'h01)
    else $error("Write pointer did not step by one.");
  empty_rise_edge_a: assert property ($rose(empty_n_r) |-> $past(b_edge))
    else $error("Empty flag rose off a read-clock edge.");
  full_rise_edge_a: assert property ($rose(full_n_r) |-> $past(a_edge))
    else $error("Full flag rose off a write-clock edge.");
  mail_store_a: assert property (a_edge && op_a.mail_wr && mflag_b_r
                                 |=> !mflag_b_r && mail_b_r == $past(a_data_in))
    else $error("Mail-to-B write not stored.");
  mail_locked_a: assert property (!mflag_b_r && !(b_edge && op_b.mail_rd)
                                  |=> mail_b_r == $past(mail_b_r) && !mflag_b_r)
    else $error("Mail-to-B changed while locked.");
  mail_read_set_a: assert property (b_edge && op_b.mail_rd |=> mflag_b_r)
    else $error("Mail-to-B flag not set by read.");
  gen_holds_pe_a: assert property (a_gen_rd |=> port_a_parity_err_n)
    else $error("Port A parity error not held high.");
  fill_cov: cover property (wr_acc ##[1:200] !full_n_r);
  drain_cov: cover property (rd_acc ##1 !empty_n_r);
  mail_cov: cover property (a_edge && op_a.mail_wr ##[1:50] b_edge && op_b.mail_rd);
endmodule
`default_nettype wire

// File: rtl/fifo_flags_pkg.sv
// Shared types for the dual-port FIFO with flags, mailboxes and parity.
package fifo_flags_pkg;
  // Control pins of one port, sampled together.
  typedef struct packed {
    logic select_n;
    logic dir;
    logic en;
    logic mail_sel;
    logic parity_gen_en;
  } port_ctrl_type;
  // Decoded operation of one port for one port-clock edge.
  typedef struct packed {
    logic fifo_wr;
    logic fifo_rd;
    logic mail_wr;
    logic mail_rd;
  } port_op_type;
endpackage

// File: rtl/two_entry_buffer.sv
// Two-entry valid/ready buffer that absorbs one stall of its sink.
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer
  import fifo_flags_pkg::*;
#(
  parameter int WIDTH = 36
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot_r [2];
  logic [WIDTH-1:0] slot_nxt [2];
  logic [1:0]       cnt_r;
  logic [1:0]       cnt_nxt;
  logic             push;
  logic             pop;

  initial begin
    if (WIDTH < 1) $error("two_entry_buffer: WIDTH must be positive.");
  end

  // Head is slot 0; a pop shifts slot 1 down, a push fills the first free slot.
  always_comb begin
    in_ready  = (cnt_r != 2'h2);
    out_valid = (cnt_r != 2'h0);
    out_data  = slot_r[0];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    slot_nxt  = slot_r;
    cnt_nxt   = cnt_r;
    if (pop) begin
      slot_nxt[0] = slot_r[1];
    end
    if (push) begin
      if (pop) begin
        slot_nxt[cnt_r - 2'h2 == 2'h0 ? 1 : 0] = in_data;
      end else begin
        slot_nxt[cnt_r[0]] = in_data;
      end
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  // State registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r     <= 2'h0;
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else begin
      cnt_r  <= cnt_nxt;
      slot_r <= slot_nxt;
    end
  end
endmodule
`default_nettype wire

// File: verification/fifo_flags_mailbox_tb_top.sv
// Self-checking bench for the dual-port FIFO with flags, mailboxes and parity.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flags_consts.svh"
module fifo_flags_mailbox_tb_top
  import fifo_flags_pkg::*;
;
  localparam int W = `FIFO_WIDTH;
  localparam port_ctrl_type c_fwr = 5'h0C;
  localparam port_ctrl_type c_frd = 5'h04;
  localparam port_ctrl_type c_mwr = 5'h0E;
  localparam port_ctrl_type c_mrd = 5'h06;
  localparam port_ctrl_type c_mgen = 5'h07;
  localparam port_ctrl_type c_idle = 5'h08;
  localparam port_ctrl_type c_fgen = 5'h05;
  typedef struct packed {logic s1; logic s0; logic [4:0] x;} row_type;
  row_type       rows [4] = '{'{1'b1, 1'b1, 5'h10}, '{1'b1, 1'b0, 5'h0C},
                              '{1'b0, 1'b1, 5'h08}, '{1'b0, 1'b0, 5'h04}};
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic          odd_sel = 1'b1;
  logic          sel0 = 1'b0;
  logic          sel1 = 1'b0;
  port_ctrl_type a_ctrl = c_idle;
  port_ctrl_type b_ctrl = c_idle;
  logic [W-1:0]  a_host = '0;
  logic [W-1:0]  b_host = '0;
  logic [W-1:0]  a_din, b_din, a_dout, b_dout;
  logic          wclk, rclk, a_oe, b_oe, empty_n, aempty_n, full_n, afull_n;
  logic          mail_b_n, mail_a_n, pe_a_n, pe_b_n;
  int            n_mismatch = 0;
  int            checks = 0;
  int            cycles = 0;

  fifo_flags_mailbox uut (
    .sys_clk(sys_clk), .rst(rst), .write_port_clock(wclk), .read_port_clock(rclk),
    .port_a_select_n(a_ctrl.select_n), .port_a_dir(a_ctrl.dir), .port_a_en(a_ctrl.en),
    .port_a_mail_sel(a_ctrl.mail_sel), .port_a_parity_gen_en(a_ctrl.parity_gen_en),
    .port_b_select_n(b_ctrl.select_n), .port_b_dir(b_ctrl.dir), .port_b_en(b_ctrl.en),
    .port_b_mail_sel(b_ctrl.mail_sel), .port_b_parity_gen_en(b_ctrl.parity_gen_en),
    .parity_odd_sel(odd_sel), .offset_sel0(sel0), .offset_sel1(sel1),
    .a_data_in(a_din), .a_data_out(a_dout), .a_data_oe(a_oe),
    .b_data_in(b_din), .b_data_out(b_dout), .b_data_oe(b_oe),
    .fifo_not_empty_n(empty_n), .almost_empty_n(aempty_n), .fifo_not_full_n(full_n),
    .almost_full_n(afull_n), .mail_to_b_flag_n(mail_b_n), .mail_to_a_flag_n(mail_a_n),
    .port_a_parity_err_n(pe_a_n), .port_b_parity_err_n(pe_b_n));

  port_host_model #(.WIDTH(W)) host (
    .sys_clk(sys_clk), .rst(rst), .write_port_clock(wclk), .read_port_clock(rclk),
    .a_host(a_host), .a_data_out(a_dout), .a_data_oe(a_oe), .a_data_in(a_din),
    .b_host(b_host), .b_data_out(b_dout), .b_data_oe(b_oe), .b_data_in(b_din));

  // System clock of 8 ns.
  always #4 sys_clk = ~sys_clk;

  // Word pattern that differs for every index from 0 to 511.
  function automatic logic [W-1:0] pat(input int k);
    return {4{k[8:0]}} ^ 36'hA_5A5A_5A5A;
  endfunction

  // Puts generated parity into the top bit of every 9-bit byte.
  function automatic logic [W-1:0] gen(input logic [W-1:0] d, input logic odd);
    for (int i = 0; i < 4; i++) begin
      d[9*i+8] = ^d[9*i+:8] ^ odd;
    end
    return d;
  endfunction

  // Moves to just after the next rising clock edge.
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // Compares one seen value against its expectation.
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic op(input logic on_b, input port_ctrl_type c, input logic [W-1:0] d);
    tick();
    if (on_b) begin
      b_ctrl = c;
      b_host = d;
    end else begin
      a_ctrl = c;
      a_host = d;
    end
    repeat (4) tick();
    a_ctrl.en = 1'b0;
    b_ctrl.en = 1'b0;
    repeat (2) tick();
  endtask

  // Resets with the given offset selects and checks the reset levels.
  task automatic do_reset(input logic s1, input logic s0);
    tick();
    sel1 = s1;
    sel0 = s0;
    rst = 1'b1;
    tick();
    check(W'({empty_n, aempty_n, full_n, afull_n, mail_b_n, mail_a_n}), W'(6'h07));
    repeat (2) tick();
    rst = 1'b0;
    repeat (12) tick();
    check(W'(full_n), W'(1'b1));
  endtask

  // Cycle ceiling that cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Offset rows first, then the awkward cases.
  initial begin
    foreach (rows[r]) begin
      do_reset(rows[r].s1, rows[r].s0);
      for (int k = 0; k <= rows[r].x; k++) begin
        op(1'b0, c_fwr, pat(k));
        repeat (12) tick();
        check(W'(aempty_n), W'(k == rows[r].x));
      end
      for (int k = 0; k <= rows[r].x; k++) begin
        op(1'b1, c_frd, '0);
        check(b_dout, pat(k));
      end
    end
    op(1'b1, c_frd, '0);
    check(b_dout, pat(4));
    op(1'b0, 5'h1C, pat(9));
    repeat (12) tick();
    check(W'(empty_n), W'(1'b0));
    op(1'b0, c_fwr, pat(50));
    repeat (12) tick();
    check(W'(empty_n), W'(1'b1));
    op(1'b1, c_frd, '0);
    check(b_dout, pat(50));
    for (int k = 0; k <= 64; k++) begin
      op(1'b0, c_fwr, pat(k + 100));
    end
    repeat (12) tick();
    check(W'({full_n, afull_n}), W'(2'h0));
    for (int k = 0; k < 64; k++) begin
      op(1'b1, c_frd, '0);
      check(b_dout, pat(k + 100));
      repeat (12) tick();
      check(W'({full_n, afull_n}), W'({1'b1, k >= 4}));
    end
    check(W'(empty_n), W'(1'b0));
    op(1'b0, c_mwr, pat(1));
    check(W'(mail_b_n), W'(1'b0));
    op(1'b0, c_mwr, pat(2));
    op(1'b1, c_mrd, '0);
    check(b_dout, pat(1));
    check(W'(mail_b_n), W'(1'b1));
    op(1'b1, c_mwr, pat(3));
    check(W'(mail_a_n), W'(1'b0));
    op(1'b0, c_mrd, '0);
    check(a_dout, pat(3));
    check(W'(mail_a_n), W'(1'b1));
    check(W'({a_oe, b_oe}), W'(2'h2));
    op(1'b1, c_frd, '0);
    check(b_dout, pat(163));
    check(W'({a_oe, b_oe}), W'(2'h3));
    for (int odd = 0; odd < 2; odd++) begin
      odd_sel = odd[0];
      op(1'b0, c_idle, '0);
      check(W'(pe_a_n), W'(!odd[0]));
      op(1'b1, c_idle, gen('0, odd[0]) ^ (36'h1 << 27));
      check(W'(pe_b_n), W'(1'b0));
      op(1'b0, c_mgen, '0);
      check(a_dout, gen(pat(3), odd[0]));
      check(W'(pe_a_n), W'(1'b1));
      op(1'b0, c_mrd, '0);
      check(a_dout, pat(3));
      op(1'b0, c_fwr, pat(7));
      repeat (12) tick();
      op(1'b1, c_fgen, '0);
      check(b_dout, gen(pat(7), odd[0]));
      op(1'b1, c_mgen, '0);
      check(b_dout, gen(pat(1), odd[0]));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: verification/port_host_model.sv
// Host-side model of both port clocks and of the shared data pins.
`timescale 1ns/1ns
`default_nettype none
module port_host_model
  import fifo_flags_pkg::*;
#(
  parameter int WIDTH = 36
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Port clocks made by the hosts.
  output logic                  write_port_clock,
  output logic                  read_port_clock,
  // Port A host drive, device drive and resolved pins.
  input  wire logic [WIDTH-1:0] a_host,
  input  wire logic [WIDTH-1:0] a_data_out,
  input  wire logic             a_data_oe,
  output logic      [WIDTH-1:0] a_data_in,
  // Port B host drive, device drive and resolved pins.
  input  wire logic [WIDTH-1:0] b_host,
  input  wire logic [WIDTH-1:0] b_data_out,
  input  wire logic             b_data_oe,
  output logic      [WIDTH-1:0] b_data_in
);
  logic [1:0] phase_r;

  // Phase counter; each port clock has a period of four system cycles.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign write_port_clock = phase_r[1];
  assign read_port_clock  = ~phase_r[1];

  // The pins carry the device's word whenever it drives them.
  assign a_data_in = a_data_oe ? a_data_out : a_host;
  assign b_data_in = b_data_oe ? b_data_out : b_host;
endmodule
`default_nettype wire
